/* File: core/rcs_top.sv */
// refresh mode control and card strobe timing registers
// Notes on behaviour
// R1 - with refresh enable at 0 no refresh of any kind is issued.
// R2 - with refresh enabled the kind select bit picks periodic or self-refresh.
// R3 - enable set and kind 0 issues periodic refresh at the timer period.
// R4 - a periodic request during a bus cycle ends that cycle, then refreshes.
// R5 - enable set and kind 1 lets a running bus cycle finish, then enters self-refresh.
// R6 - while in self-refresh every refresh request is ignored.
// R7 - software picks a refresh kind only with the enable bit set.
// R8 - the lowest memory control bit reads 0 and should be written 0.
// R9 - the card timing register is a 16-bit read/write register.
// R10 - strobe assert width follows the wait codes, not the card timing assert delay bits.
// R11 - bit 15 is the top of the four-bit area 6 wait code.
// R12 - bit 14 is the top of the four-bit area 5 wait code, mapped as area 6.
// R13 - software keeps a wait extend bit 0 for an area that is no card area.
// R14 - card timing bits 13 and 12 read 0 and should be written 0.
// R15 - bits 11,7,6 give the area 5 assert delay of code plus one half cycles.
// R16 - all these fields clear to zero at reset; the refresh timer constant here resets to 8'h40 instead.
`timescale 1ns/100ps
module rcs_top (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        bus_active,
  output logic             bus_abort,
  output logic             refresh_cmd,
  output logic             self_refresh,
  output logic [3:0]       area5_wait_code,
  output logic [3:0]       area6_wait_code,
  output logic [4:0]       area5_wait_states,
  output logic [4:0]       area6_wait_states,
  output logic [4:0]       area5_burst_states,
  output logic [4:0]       area6_burst_states,
  output logic [3:0]       area5_assert_half
);
  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [2:0]  mem_ctl;
  logic [15:0] card_strobe_timing;
  logic [5:0]  wait_control_second;
  logic [7:0]  refresh_timer_constant;
  logic [2:0]  next_mem_ctl;
  logic [15:0] next_card;
  logic [5:0]  next_wait2;
  logic [7:0]  next_tconst;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        next_wr_pend;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_hrdata;
  logic        refresh_enable;
  logic        refresh_kind_select;
  logic        addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // refresh control state
  rcs_pkg::rcs_state_t state;
  rcs_pkg::rcs_state_t next_state;
  logic        pending;
  logic        next_pending;
  logic        timer_req;
  logic        pend_clr;
  logic [3:0]  a5_code;
  logic [3:0]  a6_code;
  logic [2:0]  a5_ted;
  logic        next_refresh_cmd;
  logic        next_self_refresh;
  logic        next_bus_abort;
  logic [3:0]  next_area5_wait_code;
  logic [3:0]  next_area6_wait_code;
  logic [4:0]  next_area5_wait_states;
  logic [4:0]  next_area6_wait_states;
  logic [4:0]  next_area5_burst_states;
  logic [4:0]  next_area6_burst_states;
  logic [3:0]  next_area5_assert_half;

  assign refresh_enable      = mem_ctl[rcs_pkg::REF_EN_BIT];
  assign refresh_kind_select = mem_ctl[rcs_pkg::REF_KIND_BIT];
  assign addr_ok = hsel && htrans[1] && hready;
  assign a6_code = {card_strobe_timing[rcs_pkg::A6_EXT_BIT],
                    wait_control_second[rcs_pkg::A6_WLOW_LO +: 3]}; // see R11
  assign a5_code = {card_strobe_timing[rcs_pkg::A5_EXT_BIT],
                    wait_control_second[rcs_pkg::A5_WLOW_LO +: 3]}; // see R12
  assign a5_ted  = {card_strobe_timing[rcs_pkg::A5_TED_TOP],
                    card_strobe_timing[rcs_pkg::A5_TED_LO +: 2]};

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait; writes land in the data phase
  always_comb
  begin
    next_mem_ctl = mem_ctl;
    next_card    = card_strobe_timing;
    next_wait2   = wait_control_second;
    next_tconst  = refresh_timer_constant;
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
    next_hrdata  = hrdata;
    if (wr_pend)
    begin
      unique case (wr_addr)
        rcs_pkg::MEM_CTL_OFF: next_mem_ctl = hwdata[2:0] & rcs_pkg::MEM_CTL_MASK; // see R8
        rcs_pkg::CARD_OFF:    next_card    = hwdata[15:0] & rcs_pkg::CARD_MASK;  // see R9 see R14
        rcs_pkg::WAIT2_OFF:   next_wait2   = hwdata[5:0] & rcs_pkg::WAIT2_MASK;
        rcs_pkg::TCONST_OFF:  next_tconst  = hwdata[7:0];
        default:              next_tconst  = refresh_timer_constant;
      endcase
    end
    if (addr_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        rcs_pkg::MEM_CTL_OFF: next_hrdata = {29'h0, mem_ctl};
        rcs_pkg::CARD_OFF:    next_hrdata = {16'h0, card_strobe_timing};
        rcs_pkg::WAIT2_OFF:   next_hrdata = {26'h0, wait_control_second};
        rcs_pkg::TCONST_OFF:  next_hrdata = {24'h0, refresh_timer_constant};
        rcs_pkg::STATUS_OFF:  next_hrdata = {29'h0, pending, state};
        default:              next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_ctl                <= rcs_pkg::MEM_CTL_RST; // see R16
      card_strobe_timing     <= rcs_pkg::CARD_RST;
      wait_control_second    <= rcs_pkg::WAIT2_RST;
      refresh_timer_constant <= rcs_pkg::TCONST_RST;
      wr_pend                <= 1'b0;
      wr_addr                <= 8'h00;
      hrdata                 <= 32'h0;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
    end
    else
    begin
      mem_ctl                <= next_mem_ctl;
      card_strobe_timing     <= next_card;
      wait_control_second    <= next_wait2;
      refresh_timer_constant <= next_tconst;
      wr_pend                <= next_wr_pend;
      wr_addr                <= next_wr_addr;
      hrdata                 <= next_hrdata;
      hreadyout              <= 1'b1;
      hresp                  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refresh request source
  rcs_refresh_timer #(
    .W        (8)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .run      (refresh_enable),
    .period   (refresh_timer_constant),
    .req      (timer_req)
  );

  ////////////////////////////////////////////////////////////////////////
  // refresh sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      rcs_pkg::ST_IDLE:
      begin
        if (refresh_enable && refresh_kind_select) // see R2
          next_state = bus_active ? rcs_pkg::ST_DRAIN : rcs_pkg::ST_SELF; // see R5
        else if (refresh_enable && pending) // see R1 see R3
          next_state = bus_active ? rcs_pkg::ST_DRAIN : rcs_pkg::ST_REFR; // see R4
      end
      rcs_pkg::ST_DRAIN:
      begin
        if (!refresh_enable)
          next_state = rcs_pkg::ST_IDLE; // see R1
        else if (!bus_active)
          next_state = refresh_kind_select ? rcs_pkg::ST_SELF : rcs_pkg::ST_REFR;
      end
      rcs_pkg::ST_REFR:
        next_state = rcs_pkg::ST_IDLE;
      rcs_pkg::ST_SELF:
      begin
        if (!(refresh_enable && refresh_kind_select))
          next_state = rcs_pkg::ST_IDLE;
      end
    endcase
  end

  // a request landing on the clearing edge survives
  always_comb
  begin
    pend_clr = (state == rcs_pkg::ST_REFR) || (state == rcs_pkg::ST_SELF) || !refresh_enable
               || refresh_kind_select; // see R6
    next_pending = (timer_req && refresh_enable && !refresh_kind_select
                    && (state != rcs_pkg::ST_SELF)) // see R6
                   || (pending && !pend_clr);
    next_refresh_cmd  = (next_state == rcs_pkg::ST_REFR); // see R3
    next_self_refresh = (next_state == rcs_pkg::ST_SELF); // see R5
    next_bus_abort    = (next_state == rcs_pkg::ST_DRAIN) && !refresh_kind_select && bus_active; // see R4
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state        <= rcs_pkg::ST_IDLE;
      pending      <= 1'b0;
      refresh_cmd  <= 1'b0;
      self_refresh <= 1'b0;
      bus_abort    <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      pending      <= next_pending;
      refresh_cmd  <= next_refresh_cmd;
      self_refresh <= next_self_refresh;
      bus_abort    <= next_bus_abort;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // card timing decode; strobe width from wait codes only
  always_comb
  begin
    next_area5_wait_code    = a5_code;
    next_area6_wait_code    = a6_code;
    next_area5_wait_states  = rcs_pkg::wait_states(a5_code); // see R10 see R12
    next_area6_wait_states  = rcs_pkg::wait_states(a6_code); // see R10 see R11
    next_area5_burst_states = rcs_pkg::burst_states(a5_code);
    next_area6_burst_states = rcs_pkg::burst_states(a6_code);
    next_area5_assert_half  = {a5_ted, 1'b1}; // see R15
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      area5_wait_code    <= 4'h0;
      area6_wait_code    <= 4'h0;
      area5_wait_states  <= 5'h00;
      area6_wait_states  <= 5'h00;
      area5_burst_states <= rcs_pkg::BURST_MIN;
      area6_burst_states <= rcs_pkg::BURST_MIN;
      area5_assert_half  <= 4'h1;
    end
    else
    begin
      area5_wait_code    <= next_area5_wait_code;
      area6_wait_code    <= next_area6_wait_code;
      area5_wait_states  <= next_area5_wait_states;
      area6_wait_states  <= next_area6_wait_states;
      area5_burst_states <= next_area5_burst_states;
      area6_burst_states <= next_area6_burst_states;
      area5_assert_half  <= next_area5_assert_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence rd_mem_s;
    addr_ok && !hwrite && (haddr[7:0] == rcs_pkg::MEM_CTL_OFF);
  endsequence

  sequence wr_card_s;
    addr_ok && hwrite && (haddr[7:0] == rcs_pkg::CARD_OFF);
  endsequence

  sequence rd_card_s;
    addr_ok && !hwrite && (haddr[7:0] == rcs_pkg::CARD_OFF);
  endsequence

  // two idle cycles: the write has landed before the read is taken
  sequence gap_s;
    !addr_ok [*2];
  endsequence

  sequence periodic_due_s;
    (state == rcs_pkg::ST_IDLE) && pending && refresh_enable && !refresh_kind_select;
  endsequence

  refresh_cause_a: assert property (refresh_cmd |-> $past(refresh_enable && !refresh_kind_select)) // see R3
    else $error("refresh issued without periodic mode");
  refresh_off_a: assert property (!refresh_enable [*2] |-> !refresh_cmd && !self_refresh) // see R1
    else $error("refresh activity while disabled");
  self_mode_a: assert property (self_refresh |-> $past(refresh_enable && refresh_kind_select)) // see R2
    else $error("self-refresh without its mode");
  abort_busy_a: assert property ((state == rcs_pkg::ST_IDLE) && pending && refresh_enable
                                 && !refresh_kind_select && bus_active |=> bus_abort) // see R4
    else $error("bus cycle not ended for refresh");
  self_waits_a: assert property ($rose(self_refresh) |-> $past(!bus_active)) // see R5
    else $error("self-refresh entered during bus cycle");
  self_quiet_a: assert property (self_refresh |-> !refresh_cmd && !pending) // see R6
    else $error("refresh during self-refresh");
  mem_resv_a: assert property (rd_mem_s |=> hrdata[0] == 1'b0) // see R8
    else $error("reserved memory control bit reads 1");
  card_rw_a: assert property (wr_card_s ##1 gap_s ##1 rd_card_s
                              |=> hrdata[15:0] == ($past(hwdata[15:0], 3) & rcs_pkg::CARD_MASK)) // see R9
    else $error("card timing readback wrong");
  card_resv_a: assert property (card_strobe_timing[13:12] == 2'b00) // see R14
    else $error("card reserved bits set");
  a6_code_a: assert property (area6_wait_code == $past(a6_code)) // see R11
    else $error("area 6 wait code wrong");
  a5_delay_a: assert property (area5_assert_half == $past({a5_ted, 1'b1})
                               && area5_assert_half[0]) // see R15
    else $error("area 5 assert delay wrong");
  refresh_due_a: assert property (periodic_due_s ##0 !bus_active |=> refresh_cmd) // see R3
    else $error("due refresh not issued");
  abort_cause_a: assert property (bus_abort |-> $past(bus_active)) // see R4
    else $error("bus abort without bus cycle");
  self_no_abort_a: assert property ($past(refresh_kind_select) |-> !bus_abort) // see R5
    else $error("bus cycle ended for self-refresh");
  card_wr_a: assert property (wr_pend && (wr_addr == rcs_pkg::CARD_OFF)
                              |=> card_strobe_timing == ($past(hwdata[15:0]) & rcs_pkg::CARD_MASK)) // see R9
    else $error("card timing write lost");
  mem_bit0_a: assert property (mem_ctl[0] == 1'b0) // see R8
    else $error("reserved memory control bit set");
  a5_code_a: assert property (area5_wait_code == $past(a5_code)) // see R12
    else $error("area 5 wait code wrong");
  a6_waits_a: assert property (area6_wait_states == ((area6_wait_code < 4'h4) ? {1'b0, area6_wait_code}
                               : 5'({area6_wait_code, 1'b0} - 5'h04))) // see R11
    else $error("area 6 wait states wrong");
  a5_waits_a: assert property (area5_wait_states == ((area5_wait_code < 4'h4) ? {1'b0, area5_wait_code}
                               : 5'({area5_wait_code, 1'b0} - 5'h04))) // see R12
    else $error("area 5 wait states wrong");
  a6_burst_a: assert property (area6_burst_states == ((area6_wait_code == 4'h0) ? rcs_pkg::BURST_MIN
                               : 5'(area6_wait_states + 5'h01))) // see R11
    else $error("area 6 burst states wrong");
  strobe_width_a: assert property ($stable(wait_control_second) && $stable(card_strobe_timing[15:14])
                                   |=> $stable(area5_wait_states) && $stable(area6_wait_states)) // see R10
    else $error("strobe width follows delay bits");
endmodule // rcs_top

/* File: core/rcs_pkg.sv */
// constants, layouts and helpers of the refresh and card strobe block
package rcs_pkg;
  localparam int         CLK_MHZ        = 250;
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] MEM_CTL_OFF    = 8'h00;
  localparam logic [7:0] CARD_OFF       = 8'h04;
  localparam logic [7:0] WAIT2_OFF      = 8'h08;
  localparam logic [7:0] TCONST_OFF     = 8'h0c;
  localparam logic [7:0] STATUS_OFF     = 8'h10;
  localparam int         REF_EN_BIT     = 2;
  localparam int         REF_KIND_BIT   = 1;
  localparam int         A6_EXT_BIT     = 15;
  localparam int         A5_EXT_BIT     = 14;
  localparam int         A5_TED_TOP     = 11;
  localparam int         A5_TED_LO      = 6;
  localparam int         A5_WLOW_LO     = 0;
  localparam int         A6_WLOW_LO     = 3;
  localparam logic [15:0] CARD_MASK     = 16'hcfff;
  localparam logic [2:0] MEM_CTL_MASK   = 3'h6;
  localparam logic [5:0] WAIT2_MASK     = 6'h3f;
  localparam logic [2:0] MEM_CTL_RST    = 3'h0;
  localparam logic [15:0] CARD_RST      = 16'h0000;
  localparam logic [5:0] WAIT2_RST      = 6'h00;
  localparam logic [7:0] TCONST_RST     = 8'h40;
  localparam logic [4:0] BURST_MIN      = 5'h02;
  localparam logic [3:0] WAIT_LIN_TOP   = 4'h3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DRAIN = 2'b01,
    ST_REFR  = 2'b10,
    ST_SELF  = 2'b11
  } rcs_state_t;

  // code 0..3 inserts that many waits, above that two per step
  function automatic logic [4:0] wait_states(input logic [3:0] code);
    if (code <= WAIT_LIN_TOP)
      wait_states = {1'b0, code};
    else
      wait_states = 5'({code, 1'b0} - 5'h04);
  endfunction

  function automatic logic [4:0] burst_states(input logic [3:0] code);
    if (code == 4'h0)
      burst_states = BURST_MIN;
    else
      burst_states = 5'(wait_states(code) + 5'h01);
  endfunction
endpackage

/* File: core/rcs_refresh_timer.sv */
// periodic refresh request timer
`timescale 1ns/100ps
module rcs_refresh_timer #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         run,
  input  wire logic [W-1:0] period,
  output logic              req
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_req;

  always_comb
  begin
    next_cnt = cnt;
    next_req = 1'b0;
    if (!run)
      next_cnt = '0;
    else if (cnt >= period)
    begin
      next_cnt = '0;
      next_req = 1'b1;
    end
    else
      next_cnt = W'(cnt + 1'b1);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= '0;
      req <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      req <= next_req;
    end
  end
endmodule // rcs_refresh_timer

/* File: tb/rcs_mem_model.sv */
// far side model: external bus cycles and refresh counting
`timescale 1ns/100ps
module rcs_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        start,
  input  wire logic [7:0]  len,
  input  wire logic        bus_abort,
  input  wire logic        refresh_cmd,
  output logic             bus_active,
  output logic             abort_seen,
  output logic [15:0]      refresh_count
);
  logic [7:0] left;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      left          <= 8'h00;
      bus_active    <= 1'b0;
      abort_seen    <= 1'b0;
      refresh_count <= 16'h0000;
    end
    else
    begin
      if (start)
      begin
        left       <= len;
        bus_active <= 1'b1;
        abort_seen <= 1'b0;
      end
      else if (bus_active && bus_abort)
      begin
        bus_active <= 1'b0;
        abort_seen <= 1'b1;
      end
      else if (left > 8'h01)
        left <= left - 8'h01;
      else
        bus_active <= 1'b0;
      if (refresh_cmd)
        refresh_count <= refresh_count + 16'h0001;
    end
  end
endmodule // rcs_mem_model

/* File: tb/rcs_top_tb.sv */
// register and refresh tests of the refresh and card strobe block
`timescale 1ns/100ps
module rcs_top_tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic start = 1'b0;
  logic [7:0] len = 8'h00;
  wire logic hready, hresp, bus_active, bus_abort, refresh_cmd, self_refresh, abort_seen;
  wire logic [31:0] hrdata;
  wire logic [3:0] a5_code, a6_code, a5_half;
  wire logic [4:0] a5_w, a6_w, a5_b, a6_b;
  wire logic [15:0] refresh_count;
  int num_errors = 0;
  int samples_checked = 0;
  logic [15:0] snap;
  logic [3:0] c;
  logic [2:0] n;
  logic [4:0] exp_w [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e};
  logic [4:0] exp_b [10] = '{5'h02, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h09, 5'h0b, 5'h0d, 5'h0f};

  always #2 core_clk = ~core_clk;

  rcs_top u_dut (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(hresp), .bus_active(bus_active), .bus_abort(bus_abort), .refresh_cmd(refresh_cmd),
    .self_refresh(self_refresh), .area5_wait_code(a5_code), .area6_wait_code(a6_code),
    .area5_wait_states(a5_w), .area6_wait_states(a6_w), .area5_burst_states(a5_b),
    .area6_burst_states(a6_b), .area5_assert_half(a5_half));

  rcs_mem_model u_mem (.core_clk(core_clk), .rstn(rstn), .start(start), .len(len), .bus_abort(bus_abort),
    .refresh_cmd(refresh_cmd), .bus_active(bus_active), .abort_seen(abort_seen),
    .refresh_count(refresh_count));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    r = hrdata;
    check("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
    @(posedge core_clk);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    check(name, r, exp);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cycles(20000);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    cycles(10);
    rstn <= 1'b1;
    @(posedge core_clk);
    check("hready", 32'(hready), 32'h1);
    rd("mem ctl", rcs_pkg::MEM_CTL_OFF, 32'h0);
    rd("card", rcs_pkg::CARD_OFF, 32'h0);
    rd("tconst", rcs_pkg::TCONST_OFF, 32'h40);
    check("a5 half", 32'(a5_half), 32'h1);
    wr(8'h20, 32'hffffffff);
    rd("unmapped", 8'h20, 32'h0);
    wr(rcs_pkg::CARD_OFF, 32'hffffffff);
    rd("card", rcs_pkg::CARD_OFF, 32'h0000cfff);
    $display("registers done");

    for (int i = 0; i < 10; i++)
    begin
      c = 4'(i);
      n = 3'(i);
      wr(rcs_pkg::WAIT2_OFF, {26'h0, c[2:0], c[2:0]});
      wr(rcs_pkg::CARD_OFF, {16'h0, c[3], c[3], 2'h3, n[2], 3'h7, n[1:0], 6'h3f});
      rd("card", rcs_pkg::CARD_OFF, {16'h0, c[3], c[3], 2'h0, n[2], 3'h7, n[1:0], 6'h3f});
      rd("wait2", rcs_pkg::WAIT2_OFF, {26'h0, c[2:0], c[2:0]});
      check("a6 code", 32'(a6_code), 32'(c));
      check("a5 code", 32'(a5_code), 32'(c));
      check("a6 waits", 32'(a6_w), 32'(exp_w[i]));
      check("a5 waits", 32'(a5_w), 32'(exp_w[i]));
      check("a6 burst", 32'(a6_b), 32'(exp_b[i]));
      check("a5 burst", 32'(a5_b), 32'(exp_b[i]));
      check("a5 half", 32'(a5_half), 32'({n, 1'b1}));
    end
    // wait extend bits back to 0 once no card area is in use
    wr(rcs_pkg::CARD_OFF, 32'h0);
    $display("card timing done");

    wr(rcs_pkg::TCONST_OFF, 32'h10);
    snap = refresh_count;
    cycles(100);
    check("no refresh", 32'(refresh_count), 32'(snap));
    snap = refresh_count;
    wr(rcs_pkg::MEM_CTL_OFF, 32'h4);
    cycles(60);
    check("periodic", 32'(refresh_count >= snap + 16'h3), 32'h1);
    check("no self", 32'(self_refresh), 32'h0);
    $display("periodic done");

    snap = refresh_count;
    start <= 1'b1;
    len <= 8'hc8;
    @(posedge core_clk);
    start <= 1'b0;
    cycles(40);
    check("abort", 32'(abort_seen), 32'h1);
    check("bus ended", 32'(bus_active), 32'h0);
    check("refresh after", 32'(refresh_count > snap), 32'h1);
    $display("abort done");

    wr(rcs_pkg::MEM_CTL_OFF, 32'h0);
    start <= 1'b1;
    len <= 8'h1e;
    @(posedge core_clk);
    start <= 1'b0;
    wr(rcs_pkg::MEM_CTL_OFF, 32'h7);
    cycles(10);
    check("self wait", 32'(self_refresh), 32'h0);
    check("bus runs", 32'(bus_active), 32'h1);
    cycles(25);
    check("self on", 32'(self_refresh), 32'h1);
    check("no abort", 32'(abort_seen), 32'h0);
    snap = refresh_count;
    cycles(60);
    check("self quiet", 32'(refresh_count), 32'(snap));
    rd("status", rcs_pkg::STATUS_OFF, 32'h3);
    rd("mem ctl", rcs_pkg::MEM_CTL_OFF, 32'h6);
    wr(rcs_pkg::MEM_CTL_OFF, 32'h4);
    cycles(3);
    check("self off", 32'(self_refresh), 32'h0);
    wr(rcs_pkg::MEM_CTL_OFF, 32'h0);
    $display("self refresh done");
    give_verdict();
  end
endmodule // rcs_top_tb
